// [hw/ssa_alu.sv]
`timescale 1ns/1ps
// Overview of operation
// RULE_01: Signed add-sub-exchange: top = sat16(first top + second bottom).
// RULE_02: Signed add-sub-exchange: bottom = sat16(first bottom - second top).
// RULE_03: Signed sub-add-exchange: bottom sum, top difference, exchanged.
// RULE_04: Exchange and unsigned parallel forms leave NZCV flags alone.
// RULE_05: Doubling add: sat(first + sat(2*second)).
// RULE_06: Doubling subtract: sat(first - sat(2*second)).
// RULE_07: Both doubling and add/subtract clamp to signed 32-bit.
// RULE_08: Clamping in either doubling step sets the sticky flag.
// RULE_09: Unsigned add-sub-exchange: top sum, bottom difference, clamp 0..65535.
// RULE_10: Unsigned sub-add-exchange: top difference, bottom sum, clamped.
// RULE_11: Unsigned halfword add clamps each lane to 0..65535.
// RULE_12: Unsigned byte add clamps each of four lanes to 0..255.
// RULE_13: Unsigned halfword subtract clamps each lane to 0..65535.
// RULE_14: Unsigned byte subtract clamps each of four lanes to 0..255.
// RULE_15: Software never names stack or program counter as operands.
// RULE_16: Pack bottom-top: left shift 1..31, zero means no shift.
// RULE_17: Pack top-bottom: arithmetic right shift 1..32, zero encodes 32.
// RULE_18: Pack bottom-top keeps first bottom, takes shifted top.
// RULE_19: Pack top-bottom keeps first top, takes shifted bottom.
// RULE_20: Sticky flag only set by saturation, cleared by status write.
// RULE_21: Failed condition writes neither destination nor sticky flag.
module ssa_alu
    import ssa_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              resetn,
    input  wire ssa_pkg::ssa_req_t req,
    input  wire logic              sat_clear,
    output      ssa_pkg::ssa_res_t res,
    output      logic              sat_flag,
    output      logic              nzcv_write
);
    import ssa_pkg::*;

    ssa_lane_t lane_res;
    ssa_lane_t dbl_res;
    ssa_res_t  next_res;
    logic      next_sat;

    ssa_lanes u_lanes (
        .op     (req.op),
        .first  (req.first),
        .second (req.second),
        .result (lane_res)
    );

    ssa_double u_double (
        .first    (req.first),
        .second   (req.second),
        .subtract (req.op == SSA_OP_DOUBLING_SATURATING_SUBTRACT),
        .result   (dbl_res)
    );

    wire logic is_dbl = req.op == SSA_OP_DOUBLING_SATURATING_ADD
                     || req.op == SSA_OP_DOUBLING_SATURATING_SUBTRACT;
    wire logic is_pkbt = req.op == SSA_OP_PACK_BOTTOM_TOP;
    wire logic is_pktb = req.op == SSA_OP_PACK_TOP_BOTTOM;
    wire logic is_op   = req.op != SSA_OP_NONE;
    wire logic fire    = req.valid & req.cond_pass & is_op; // RULE_21

    // Shift operand of the packing forms
    wire logic [31:0] lsl_val = req.second << req.shamt; // RULE_16
    wire logic [5:0]  asr_amt = (req.shamt == SHAMT_ZERO) ? 6'd32
                                : {1'b0, req.shamt}; // RULE_17
    wire logic [31:0] asr_val = (asr_amt == 6'd32)
                                ? {32{req.second[31]}}
                                : 32'($signed(req.second) >>> asr_amt); // RULE_17

    wire logic [31:0] pkbt = {lsl_val[31:16], req.first[15:0]};  // RULE_18
    wire logic [31:0] pktb = {req.first[31:16], asr_val[15:0]};  // RULE_19

    wire logic [31:0] sel_data = is_dbl  ? dbl_res.data
                               : is_pkbt ? pkbt
                               : is_pktb ? pktb
                               : lane_res.data;
    wire logic sat_event = fire & is_dbl & dbl_res.sat; // RULE_08

    always_comb begin
        next_res.write = fire;
        next_res.rd    = req.rd;
        next_res.data  = fire ? sel_data : res.data; // RULE_21
        // Set beats clear in the same cycle
        next_sat = sat_event ? 1'b1 : (sat_clear ? 1'b0 : sat_flag); // RULE_20
    end

    // None of these forms updates the condition flags
    assign nzcv_write = 1'b0; // RULE_04

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            res      <= '0;
            sat_flag <= SAT_RESET;
        end else begin
            res      <= next_res;
            sat_flag <= next_sat;
        end
    end

    a_sat_set_cause: assert property (@(posedge clk) disable iff (!resetn)
        sat_event |=> sat_flag) // RULE_08
        else $error("sticky flag not set after saturation");

    a_sat_hold_quiet: assert property (@(posedge clk) disable iff (!resetn)
        (!sat_event && !sat_clear) |=> sat_flag == $past(sat_flag)) // RULE_20
        else $error("sticky flag changed without cause");

    a_sat_clear_only: assert property (@(posedge clk) disable iff (!resetn)
        $fell(sat_flag) |-> $past(sat_clear)) // RULE_20
        else $error("sticky flag cleared without status write");

    a_cond_fail_mute: assert property (@(posedge clk) disable iff (!resetn)
        (req.valid && !req.cond_pass) |=> !res.write
            && (sat_flag == $past(sat_flag) || $past(sat_clear))) // RULE_21
        else $error("failed condition had an effect");

    a_write_follow: assert property (@(posedge clk) disable iff (!resetn)
        fire |=> res.write && res.rd == $past(req.rd)) // RULE_21
        else $error("destination write missing");

    a_pkbt_bottom: assert property (@(posedge clk) disable iff (!resetn)
        (fire && is_pkbt)
        |=> res.data[15:0] == $past(req.first[15:0])) // RULE_18
        else $error("pack bottom-top lost first bottom");

    a_pktb_top: assert property (@(posedge clk) disable iff (!resetn)
        (fire && is_pktb)
        |=> res.data[31:16] == $past(req.first[31:16])) // RULE_19
        else $error("pack top-bottom lost first top");

    a_asr_zero_32: assert property (@(posedge clk) disable iff (!resetn)
        (fire && is_pktb && req.shamt == SHAMT_ZERO)
        |=> res.data[15:0] == {16{$past(req.second[31])}}) // RULE_17
        else $error("shift zero not decoded as 32");

    a_lsl_zero_none: assert property (@(posedge clk) disable iff (!resetn)
        (fire && is_pkbt && req.shamt == SHAMT_ZERO)
        |=> res.data[31:16] == $past(req.second[31:16])) // RULE_16
        else $error("zero left shift altered operand");

    a_nzcv_still: assert property (@(posedge clk) disable iff (!resetn)
        fire |-> !nzcv_write) // RULE_04
        else $error("condition flags written");

    a_ubyte_clamp: assert property (@(posedge clk) disable iff (!resetn)
        (fire && req.op == SSA_OP_UNSIGNED_BYTE_SAT_ADD
              && (9'(req.first[7:0]) + 9'(req.second[7:0])) > 9'h0FF)
        |=> res.data[7:0] == U8_MAX) // RULE_12
        else $error("byte add did not clamp");
endmodule : ssa_alu

// [pkg/ssa_pkg.sv]
package ssa_pkg;

    localparam int unsigned DATA_W      = 32;
    localparam int unsigned HALF_W      = 16;
    localparam int unsigned BYTE_W      = 8;
    localparam int unsigned SHAMT_W     = 5;
    localparam logic        SAT_RESET   = 1'b0;
    localparam logic [31:0] S32_MAX     = 32'h7FFF_FFFF;
    localparam logic [31:0] S32_MIN     = 32'h8000_0000;
    localparam logic [15:0] S16_MAX     = 16'h7FFF;
    localparam logic [15:0] S16_MIN     = 16'h8000;
    localparam logic [15:0] U16_MAX     = 16'hFFFF;
    localparam logic [7:0]  U8_MAX      = 8'hFF;
    localparam logic [15:0] ZERO16      = 16'h0000;
    localparam logic [7:0]  ZERO8       = 8'h00;
    localparam logic [4:0]  SHAMT_ZERO  = 5'h00;
    localparam int unsigned LATENCY     = 1;

    typedef enum logic [3:0] {
        SSA_OP_NONE,
        SSA_OP_SIGNED_ADD_SUB_EXCHANGE_SAT,
        SSA_OP_SIGNED_SUB_ADD_EXCHANGE_SAT,
        SSA_OP_DOUBLING_SATURATING_ADD,
        SSA_OP_DOUBLING_SATURATING_SUBTRACT,
        SSA_OP_UNSIGNED_ADD_SUB_EXCHANGE_SAT,
        SSA_OP_UNSIGNED_SUB_ADD_EXCHANGE_SAT,
        SSA_OP_UNSIGNED_HALFWORD_SAT_ADD,
        SSA_OP_UNSIGNED_BYTE_SAT_ADD,
        SSA_OP_UNSIGNED_HALFWORD_SAT_SUBTRACT,
        SSA_OP_UNSIGNED_BYTE_SAT_SUBTRACT,
        SSA_OP_PACK_BOTTOM_TOP,
        SSA_OP_PACK_TOP_BOTTOM
    } ssa_op_t;

    typedef struct packed {
        logic        valid;
        logic        cond_pass;
        ssa_op_t     op;
        logic [3:0]  rd;
        logic [31:0] first;
        logic [31:0] second;
        logic [4:0]  shamt;
    } ssa_req_t;

    typedef struct packed {
        logic        write;
        logic [3:0]  rd;
        logic [31:0] data;
    } ssa_res_t;

    typedef struct packed {
        logic [31:0] data;
        logic        sat;
    } ssa_lane_t;

endpackage : ssa_pkg

// [hw/ssa_lanes.sv]
`timescale 1ns/1ps
module ssa_lanes
    import ssa_pkg::*;
(
    input  wire ssa_pkg::ssa_op_t op,
    input  wire logic [31:0]      first,
    input  wire logic [31:0]      second,
    output      ssa_pkg::ssa_lane_t result
);
    // Signed 16-bit clamp of a 17-bit value
    function automatic logic [15:0] sat_s16(input logic [16:0] v);
        if (v[16] != v[15])
            return v[16] ? S16_MIN : S16_MAX;
        return v[15:0];
    endfunction : sat_s16

    // Unsigned clamp; bit 16 is carry on add, borrow on subtract
    function automatic logic [15:0] sat_u16(input logic [16:0] v,
                                            input logic       is_sub);
        if (v[16])
            return is_sub ? ZERO16 : U16_MAX;
        return v[15:0];
    endfunction : sat_u16

    function automatic logic [7:0] sat_u8(input logic [8:0] v,
                                          input logic      is_sub);
        if (v[8])
            return is_sub ? ZERO8 : U8_MAX;
        return v[7:0];
    endfunction : sat_u8

    function automatic logic [16:0] sx(input logic [15:0] h);
        return {h[15], h};
    endfunction : sx

    wire logic [15:0] at = first[31:16];
    wire logic [15:0] ab = first[15:0];
    wire logic [15:0] bt = second[31:16];
    wire logic [15:0] bb = second[15:0];

    // Signed exchange forms
    wire logic [16:0] s_at_p_bb = sx(at) + sx(bb);
    wire logic [16:0] s_ab_m_bt = sx(ab) - sx(bt);
    wire logic [16:0] s_ab_p_bt = sx(ab) + sx(bt);
    wire logic [16:0] s_at_m_bb = sx(at) - sx(bb);

    // Unsigned halfword terms
    wire logic [16:0] u_at_p_bb = {1'b0, at} + {1'b0, bb};
    wire logic [16:0] u_at_m_bb = {1'b0, at} - {1'b0, bb};
    wire logic [16:0] u_ab_p_bt = {1'b0, ab} + {1'b0, bt};
    wire logic [16:0] u_ab_m_bt = {1'b0, ab} - {1'b0, bt};
    wire logic [16:0] u_at_p_bt = {1'b0, at} + {1'b0, bt};
    wire logic [16:0] u_ab_p_bb = {1'b0, ab} + {1'b0, bb};
    wire logic [16:0] u_at_m_bt = {1'b0, at} - {1'b0, bt};
    wire logic [16:0] u_ab_m_bb = {1'b0, ab} - {1'b0, bb};

    logic [31:0] byte_add;
    logic [31:0] byte_sub;
    always_comb begin
        byte_add = '0;
        byte_sub = '0;
        for (int i = 0; i < 4; i++) begin
            byte_add[i*8 +: 8] = sat_u8({1'b0, first[i*8 +: 8]}
                                 + {1'b0, second[i*8 +: 8]}, 1'b0); // RULE_12
            byte_sub[i*8 +: 8] = sat_u8({1'b0, first[i*8 +: 8]}
                                 - {1'b0, second[i*8 +: 8]}, 1'b1); // RULE_14
        end
    end

    always_comb begin
        result = '0;
        unique case (op)
            SSA_OP_SIGNED_ADD_SUB_EXCHANGE_SAT: begin
                result.data[31:16] = sat_s16(s_at_p_bb); // RULE_01
                result.data[15:0]  = sat_s16(s_ab_m_bt); // RULE_02
            end
            SSA_OP_SIGNED_SUB_ADD_EXCHANGE_SAT: begin
                result.data[15:0]  = sat_s16(s_ab_p_bt); // RULE_03
                result.data[31:16] = sat_s16(s_at_m_bb); // RULE_03
            end
            SSA_OP_UNSIGNED_ADD_SUB_EXCHANGE_SAT: begin
                result.data[31:16] = sat_u16(u_ab_p_bt, 1'b0); // RULE_09
                result.data[15:0]  = sat_u16(u_at_m_bb, 1'b1); // RULE_09
            end
            SSA_OP_UNSIGNED_SUB_ADD_EXCHANGE_SAT: begin
                result.data[31:16] = sat_u16(u_at_m_bb, 1'b1); // RULE_10
                result.data[15:0]  = sat_u16(u_ab_p_bt, 1'b0); // RULE_10
            end
            SSA_OP_UNSIGNED_HALFWORD_SAT_ADD: begin
                result.data[31:16] = sat_u16(u_at_p_bt, 1'b0); // RULE_11
                result.data[15:0]  = sat_u16(u_ab_p_bb, 1'b0); // RULE_11
            end
            SSA_OP_UNSIGNED_HALFWORD_SAT_SUBTRACT: begin
                result.data[31:16] = sat_u16(u_at_m_bt, 1'b1); // RULE_13
                result.data[15:0]  = sat_u16(u_ab_m_bb, 1'b1); // RULE_13
            end
            SSA_OP_UNSIGNED_BYTE_SAT_ADD:      result.data = byte_add;
            SSA_OP_UNSIGNED_BYTE_SAT_SUBTRACT: result.data = byte_sub;
            default: result = '0;
        endcase
    end

    // Halfword and byte forms never touch the sticky flag
    wire logic unused_terms = ^{u_at_p_bb, s_ab_p_bt[0]};
endmodule : ssa_lanes

// [hw/ssa_double.sv]
`timescale 1ns/1ps
module ssa_double
    import ssa_pkg::*;
(
    input  wire logic [31:0]       first,
    input  wire logic [31:0]       second,
    input  wire logic              subtract,
    output      ssa_pkg::ssa_lane_t result
);
    // Signed 32-bit clamp of a 33-bit value
    function automatic ssa_lane_t sat_s32(input logic [32:0] v);
        ssa_lane_t r;
        r.sat  = v[32] != v[31];
        r.data = r.sat ? (v[32] ? S32_MIN : S32_MAX) : v[31:0];
        return r;
    endfunction : sat_s32

    wire logic [32:0] dbl_raw = {second, 1'b0};
    wire logic [32:0] b_ext   = {second[31], second};
    wire ssa_lane_t   dbl     = sat_s32(b_ext + b_ext); // RULE_05 RULE_06 RULE_07
    wire logic [32:0] a_ext   = {first[31], first};
    wire logic [32:0] d_ext   = {dbl.data[31], dbl.data};
    wire ssa_lane_t   fin     = sat_s32(subtract ? a_ext - d_ext
                                                 : a_ext + d_ext); // RULE_07

    assign result.data = fin.data;
    assign result.sat  = dbl.sat | fin.sat; // RULE_08

    wire logic unused_raw = ^dbl_raw;
endmodule : ssa_double

// [test/ssa_regfile_model.sv]
`timescale 1ns/1ps
// Register file side: stores what the block writes back
module ssa_regfile_model
    import ssa_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              resetn,
    input  wire ssa_pkg::ssa_res_t res,
    output      logic [31:0]       regs [0:12],
    output      int                writes
);
    // Only general registers exist as destinations
    always_ff @(posedge clk) begin
        if (res.write && res.rd <= 4'hC) begin
            regs[res.rd] <= res.data;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            writes <= 0;
        end else if (res.write) begin
            writes <= writes + 1;
        end
    end
endmodule : ssa_regfile_model

// [test/testbench.sv]
`timescale 1ns/1ps
module testbench;
    import ssa_pkg::*;
    localparam longint MX = 64'h0000_0000_7FFF_FFFF;
    localparam longint MN = -MX - 1;
    logic        clk;
    logic        resetn;
    ssa_req_t    req;
    logic        sat_clear;
    ssa_res_t    res;
    logic        sat_flag;
    logic        nzcv_write;
    logic [31:0] regs [0:12];
    int          writes;
    int          failures   = 0;
    int          num_checks = 0;
    int          cycles     = 0;
    int          exp_writes = 0;
    logic        exp_sat;
    logic        prev_w     = 1'b0;
    logic [3:0]  prev_rd;
    logic [31:0] prev_d;
    logic [31:0] da [0:5] = '{32'h7FFF_7FFF, 32'h8000_8000, 32'h0000_0000,
                              32'hFFFF_FFFF, 32'h7FFF_FFF0, 32'h1234_8765};
    logic [31:0] db [0:5] = '{32'h0001_0001, 32'h0001_7FFF, 32'hFFFF_FFFF,
                              32'hFFFF_FFFF, 32'h4000_0000, 32'hC000_0001};
    logic [4:0]  shs [0:2] = '{5'h00, 5'h01, 5'h1F};

    ssa_alu dut_u (.clk(clk), .resetn(resetn), .req(req),
        .sat_clear(sat_clear), .res(res), .sat_flag(sat_flag),
        .nzcv_write(nzcv_write));
    ssa_regfile_model rf_u (.clk(clk), .resetn(resetn), .res(res),
        .regs(regs), .writes(writes));

    always #2.5 clk = ~clk;

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            failures++;
            results();
        end
    end

    task automatic results();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : results

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected at %0t: seen %h want %h", $time, seen, exp);
        end
    endtask : check

    function automatic longint clamp(input longint v, input longint lo,
                                     input longint hi, inout logic s);
        if (v < lo || v > hi) s = 1'b1;
        return (v < lo) ? lo : ((v > hi) ? hi : v);
    endfunction : clamp

    function automatic logic [32:0] model(input ssa_op_t op,
        input logic [31:0] a, input logic [31:0] b, input logic [4:0] sh);
        longint      ah, al, bh, bl, uah, ual, ubh, ubl, v;
        logic        s;
        logic [31:0] t;
        s = 1'b0;
        t = 32'h0000_0000;
        ah = $signed(a[31:16]);
        al = $signed(a[15:0]);
        bh = $signed(b[31:16]);
        bl = $signed(b[15:0]);
        uah = a[31:16];
        ual = a[15:0];
        ubh = b[31:16];
        ubl = b[15:0];
        case (op)
            SSA_OP_SIGNED_ADD_SUB_EXCHANGE_SAT: begin
                t[31:16] = 16'(clamp(ah + bl, -32768, 32767, s));
                t[15:0] = 16'(clamp(al - bh, -32768, 32767, s));
            end
            SSA_OP_SIGNED_SUB_ADD_EXCHANGE_SAT: begin
                t[15:0] = 16'(clamp(al + bh, -32768, 32767, s));
                t[31:16] = 16'(clamp(ah - bl, -32768, 32767, s));
            end
            SSA_OP_DOUBLING_SATURATING_ADD,
            SSA_OP_DOUBLING_SATURATING_SUBTRACT: begin
                v = clamp(2 * longint'($signed(b)), MN, MX, s);
                v = (op == SSA_OP_DOUBLING_SATURATING_ADD) ?
                    longint'($signed(a)) + v : longint'($signed(a)) - v;
                t = 32'(clamp(v, MN, MX, s));
                return {s, t};
            end
            SSA_OP_UNSIGNED_ADD_SUB_EXCHANGE_SAT: begin
                t[31:16] = 16'(clamp(ual + ubh, 0, 65535, s));
                t[15:0] = 16'(clamp(uah - ubl, 0, 65535, s));
            end
            SSA_OP_UNSIGNED_SUB_ADD_EXCHANGE_SAT: begin
                t[31:16] = 16'(clamp(uah - ubl, 0, 65535, s));
                t[15:0] = 16'(clamp(ual + ubh, 0, 65535, s));
            end
            SSA_OP_UNSIGNED_HALFWORD_SAT_ADD: begin
                t[31:16] = 16'(clamp(uah + ubh, 0, 65535, s));
                t[15:0] = 16'(clamp(ual + ubl, 0, 65535, s));
            end
            SSA_OP_UNSIGNED_HALFWORD_SAT_SUBTRACT: begin
                t[31:16] = 16'(clamp(uah - ubh, 0, 65535, s));
                t[15:0] = 16'(clamp(ual - ubl, 0, 65535, s));
            end
            SSA_OP_UNSIGNED_BYTE_SAT_ADD,
            SSA_OP_UNSIGNED_BYTE_SAT_SUBTRACT: begin
                for (int i = 0; i < 4; i++) begin
                    v = longint'(b[i*8+:8]);
                    v = (op == SSA_OP_UNSIGNED_BYTE_SAT_ADD) ?
                        longint'(a[i*8+:8]) + v : longint'(a[i*8+:8]) - v;
                    t[i*8+:8] = 8'(clamp(v, 0, 255, s));
                end
            end
            SSA_OP_PACK_BOTTOM_TOP: begin
                t = b << sh;
                t = {t[31:16], a[15:0]};
            end
            SSA_OP_PACK_TOP_BOTTOM: begin
                t = (sh == 5'h00) ? {32{b[31]}} : 32'($signed(b) >>> sh);
                t = {a[31:16], t[15:0]};
            end
            default: ;
        endcase
        return {1'b0, t};
    endfunction : model

    task automatic step(input ssa_op_t op, input logic [31:0] a,
        input logic [31:0] b, input logic [4:0] sh, input logic cp,
        input logic clr);
        logic [32:0] m;
        logic        tk;
        logic [3:0]  rd;
        rd = 4'($urandom_range(0, 12));
        m = model(op, a, b, sh);
        tk = cp && (op != SSA_OP_NONE);
        req = '{1'b1, cp, op, rd, a, b, sh};
        sat_clear = clr;
        @(posedge clk);
        #1;
        exp_sat = (exp_sat & !clr) | (tk & m[32]);
        check(32'(writes), 32'(exp_writes));
        if (prev_w) check(regs[prev_rd], prev_d);
        check(res.write, tk);
        if (tk) check(res.data, m[31:0]);
        if (tk) check(res.rd, rd);
        check(sat_flag, exp_sat);
        check(nzcv_write, 1'b0);
        exp_writes += tk;
        prev_w = tk;
        prev_rd = rd;
        prev_d = m[31:0];
    endtask : step

    task automatic do_reset();
        resetn = 1'b0;
        repeat (12) @(posedge clk);
        #1;
        check(sat_flag, 1'b0);
        check(res.write, 1'b0);
        exp_sat = 1'b0;
        exp_writes = 0;
        prev_w = 1'b0;
        resetn = 1'b1;
        $display("test reset done");
    endtask : do_reset

    initial begin
        clk = 1'b0;
        req = '0;
        sat_clear = 1'b0;
        void'($urandom(46582));
        do_reset();
        for (int k = 1; k < 13; k++) begin
            for (int j = 0; j < 6; j++) begin
                step(ssa_op_t'(k), da[j], db[j], 5'(j * 6), 1'b1, 1'b0);
            end
        end
        $display("test corners done");
        foreach (shs[j]) begin
            step(SSA_OP_PACK_BOTTOM_TOP, 32'h1234_5678, 32'h8765_4321,
                 shs[j], 1'b1, 1'b0);
            step(SSA_OP_PACK_TOP_BOTTOM, 32'h1234_5678, 32'h8765_4321,
                 shs[j], 1'b1, 1'b0);
        end
        $display("test pack shifts done");
        step(SSA_OP_NONE, 0, 0, 0, 1'b1, 1'b1);
        step(SSA_OP_DOUBLING_SATURATING_ADD, 0, 32'h4000_0000, 0, 0, 0);
        step(SSA_OP_DOUBLING_SATURATING_ADD, 1, 2, 0, 1'b1, 1'b0);
        step(SSA_OP_DOUBLING_SATURATING_SUBTRACT, 32'h8000_0000, 1, 0, 1, 0);
        step(SSA_OP_UNSIGNED_HALFWORD_SAT_ADD, '1, '1, 0, 1'b1, 1'b1);
        step(SSA_OP_DOUBLING_SATURATING_ADD, 0, 32'h4000_0000, 0, 1, 1);
        step(SSA_OP_NONE, 0, 0, 0, 1'b1, 1'b1);
        $display("test sticky flag done");
        repeat (400) begin
            step(ssa_op_t'($urandom_range(0, 12)), $urandom, $urandom,
                 5'($urandom), 1'($urandom_range(0, 7) != 0),
                 1'($urandom_range(0, 15) == 0));
        end
        $display("test random done");
        do_reset();
        step(SSA_OP_DOUBLING_SATURATING_ADD, 32'h7FFF_FFFF, 32'h0000_0001,
             5'h00, 1'b1, 1'b0);
        step(SSA_OP_NONE, 0, 0, 0, 1'b1, 1'b0);
        $display("test second reset done");
        results();
    end
endmodule : testbench
